//--- common/pwm_pkg.sv
// package: constants and types for the coded divider pwm oscillator
package pwm_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int MASTER_PERIOD_NS = 1000;
  localparam int MASTER_CYCLES    = (MASTER_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W           = 7;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MASTER_CYCLES - 1);

  // ==========================================================
  // divider code
  localparam int CODE_W     = 4;
  localparam int RATIO_K_W  = 3;
  localparam int PHASE_W    = 15;
  localparam int STABLE_W   = 5;
  localparam logic [STABLE_W-1:0] STABLE_LAST = 5'h0f;
  localparam logic [CODE_W-1:0]   CODE_RESET  = 4'h0;

  // ==========================================================
  // duty arithmetic, duty in 1/1024 steps
  localparam int LEVEL_W = 8;
  localparam int DUTY_W  = 11;
  localparam int CMP_W   = 25;
  localparam int FRAC_SHIFT = 10;
  localparam logic [DUTY_W-1:0] DUTY_GAIN   = 11'h005;
  localparam logic [DUTY_W-1:0] DUTY_OFFSET = 11'h080;
  localparam logic [DUTY_W-1:0] DUTY_FULL   = 11'h400;
  localparam logic [DUTY_W-1:0] DUTY_CL_LO  = 11'h033;
  localparam logic [DUTY_W-1:0] DUTY_CL_HI  = 11'h3cd;

  typedef enum logic [1:0] {
    CLAMP_NONE,
    CLAMP_BOTH,
    CLAMP_MAX_ONLY,
    CLAMP_MIN_ONLY
  } clamp_option_t;

endpackage

//--- common/code_if.sv
// interface: filtered divider code from the filter to the pwm core
`timescale 1ns/1ns
`default_nettype none
interface code_if;
  import pwm_pkg::*;
  logic              tick;
  logic [CODE_W-1:0] code;
  logic              valid;
  modport filter (input tick, output code, output valid);
  modport core   (output tick, input code, input valid);
endinterface
`default_nettype wire

//--- rtl/divider_code_filter.sv
// module: stability filter for the divider code input
`timescale 1ns/1ns
`default_nettype none
module divider_code_filter
  import pwm_pkg::*;
(
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  // raw code
  input  wire logic [CODE_W-1:0] i_divider_code,
  // filtered code
  code_if.filter                 cif
);

  logic [CODE_W-1:0]   cand;
  logic [CODE_W-1:0]   next_cand;
  logic [STABLE_W-1:0] cnt;
  logic [STABLE_W-1:0] next_cnt;
  logic [CODE_W-1:0]   code;
  logic [CODE_W-1:0]   next_code;
  logic                valid;
  logic                next_valid;

  // ==========================================================
  // filter: a code is accepted only after staying put for a run of master ticks
  always_comb begin
    next_cand  = cand;
    next_cnt   = cnt;
    next_code  = code;
    next_valid = valid;
    if (cif.tick) begin
      if (i_divider_code != cand) begin
        next_cand = i_divider_code;
        next_cnt  = '0;
      end else if (cnt != STABLE_LAST) begin
        next_cnt = cnt + 5'h01;
        if (cnt == STABLE_LAST - 5'h01) begin
          // jumps straight to the settled code, never through steps between
          next_code  = cand; // R13
          next_valid = 1'b1; // R1
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cand  <= CODE_RESET;
      cnt   <= '0;
      code  <= CODE_RESET;
      valid <= 1'b0;
    end else begin
      cand  <= next_cand;
      cnt   <= next_cnt;
      code  <= next_code;
      valid <= next_valid;
    end
  end

  assign cif.code  = code;
  assign cif.valid = valid;

  // ==========================================================
  // checks
  property p_accept_settled;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      cif.tick && (i_divider_code == cand) && (cnt == STABLE_LAST - 5'h01)
      |=> valid && (code == $past(cand));
  endproperty
  a_accept_settled: assert property (p_accept_settled) // R13
    else $error("settled divider code not accepted");

  property p_no_change_unsettled;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      valid && (cnt != STABLE_LAST - 5'h01) |=> $stable(code);
  endproperty
  a_no_change_unsettled: assert property (p_no_change_unsettled) // R13
    else $error("divider code changed before settling");

endmodule
`default_nettype wire

//--- rtl/coded_divider_pwm_oscillator.sv
// module: top of the coded divider pwm oscillator
// Summary of operation
// (R1) four-bit divider code sets ratio and inversion
// (R2) code top bit inverts the output
// (R3) ratios 1,4,16,...,16384 master periods
// (R4) codes 0-7 four^code; code 15-k mirrors k
// (R5) master tick at most 1 MHz sets timing
// (R6) inversion makes duty fall with control
// (R7) duty equals level over 0.8 ref, minus eighth
// (R8) control beyond range saturates duty
// (R9) unclamped option reaches steady 0% and 100%
// (R10) two-sided option keeps duty in 5-95%
// (R11) one-sided options clamp only one end
// (R12) inversion applied after clamp, ends swap
// (R13) new code only once stable, glitchless switch
// (R14) numeric control word compared with period counter
`timescale 1ns/1ns
`default_nettype none
module coded_divider_pwm_oscillator
  import pwm_pkg::*;
(
  // clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst_n,
  // static configuration
  input  wire logic [CODE_W-1:0]  i_divider_code,
  input  wire logic [1:0]         i_clamp_option,
  // duty control word, full scale equals the reference
  input  wire logic [LEVEL_W-1:0] i_duty_control_level,
  // outputs
  output logic                    o_pwm,
  output logic                    o_output_invert,
  output logic [CODE_W-1:0]       o_active_code,
  output logic                    o_running
);

  localparam int TICK_GAP = MASTER_CYCLES;

  code_if cif ();

  divider_code_filter u_filter (
    .i_ref_clk      (i_ref_clk),
    .i_rst_n        (i_rst_n),
    .i_divider_code (i_divider_code),
    .cif            (cif)
  );

  // ==========================================================
  // master oscillator tick
  logic [TICK_W-1:0] tick_cnt;
  logic [TICK_W-1:0] next_tick_cnt;
  logic              tick;
  logic              next_tick;

  always_comb begin
    next_tick     = (tick_cnt == TICK_LAST); // R5
    next_tick_cnt = next_tick ? '0 : tick_cnt + 7'h01;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick     <= next_tick;
    end
  end

  assign cif.tick = tick;

  // ==========================================================
  // duty target from the control word
  clamp_option_t     opt;
  logic [DUTY_W-1:0] scaled;
  logic [DUTY_W-1:0] duty_lin;
  logic [DUTY_W-1:0] duty_target;

  always_comb begin
    opt    = clamp_option_t'(i_clamp_option);
    // 1024*level/(0.8*256) reduces to five times the level
    scaled = DUTY_W'({3'h0, i_duty_control_level} * DUTY_GAIN); // R14
    if (scaled <= DUTY_OFFSET) begin
      duty_lin = '0; // R8
    end else if (scaled - DUTY_OFFSET >= DUTY_FULL) begin
      duty_lin = DUTY_FULL; // R8
    end else begin
      duty_lin = scaled - DUTY_OFFSET; // R7
    end
    duty_target = duty_lin; // R9
    if ((opt == CLAMP_BOTH || opt == CLAMP_MIN_ONLY) && duty_lin < DUTY_CL_LO) begin
      duty_target = DUTY_CL_LO; // R10 R11
    end
    if ((opt == CLAMP_BOTH || opt == CLAMP_MAX_ONLY) && duty_lin > DUTY_CL_HI) begin
      duty_target = DUTY_CL_HI; // R10 R11
    end
  end

  // ==========================================================
  // period counter, code and duty taken only at period boundaries
  logic [PHASE_W-1:0]   phase;
  logic [PHASE_W-1:0]   next_phase;
  logic [CODE_W-1:0]    code;
  logic [CODE_W-1:0]    next_code;
  logic [DUTY_W-1:0]    duty_lat;
  logic [DUTY_W-1:0]    next_duty_lat;
  logic                 running;
  logic                 next_running;
  logic [RATIO_K_W-1:0] ratio_k;
  logic [PHASE_W-1:0]   phase_last;
  logic                 period_end;
  logic [CMP_W-1:0]     cmp_phase;
  logic [CMP_W-1:0]     cmp_duty;
  logic                 raw_high;
  logic                 next_pwm;

  always_comb begin
    // code 15-k reads as k once the top bit is stripped and the rest flipped
    ratio_k    = code[3] ? ~code[2:0] : code[2:0]; // R4
    phase_last = PHASE_W'((16'h0001 << {ratio_k, 1'b0}) - 16'h0001); // R3
    period_end = tick && (!running || phase == phase_last);
    next_phase    = phase;
    next_code     = code;
    next_duty_lat = duty_lat;
    next_running  = running;
    if (period_end) begin
      next_phase    = '0;
      next_duty_lat = duty_target;
      if (cif.valid) begin
        // switching only at a boundary keeps the output free of runt pulses
        next_code    = cif.code; // R13
        next_running = 1'b1;
      end
    end else if (tick) begin
      next_phase = phase + 15'h0001;
    end
    // high while phase/N is below duty/1024
    cmp_phase = {phase, 10'h000}; // R14
    cmp_duty  = CMP_W'({14'h0000, duty_lat} << {ratio_k, 1'b0}); // R14
    raw_high  = cmp_phase < cmp_duty; // R9
    // plain inversion after the clamp swaps its ends and the slope sign
    next_pwm  = running && (raw_high ^ code[3]); // R2 R6 R12
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      phase           <= '0;
      code            <= CODE_RESET;
      duty_lat        <= '0;
      running         <= 1'b0;
      o_pwm           <= 1'b0;
      o_output_invert <= 1'b0;
      o_active_code   <= CODE_RESET;
      o_running       <= 1'b0;
    end else begin
      phase           <= next_phase;
      code            <= next_code;
      duty_lat        <= next_duty_lat;
      running         <= next_running;
      o_pwm           <= next_pwm;
      o_output_invert <= next_code[3]; // R2
      o_active_code   <= next_code; // R1
      o_running       <= next_running;
    end
  end

  // ==========================================================
  // checks
  property p_tick_rate;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      tick |-> ##TICK_GAP tick;
  endproperty
  a_tick_rate: assert property (p_tick_rate) // R5
    else $error("master tick spacing wrong");

  property p_invert_bit;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_output_invert == o_active_code[3];
  endproperty
  a_invert_bit: assert property (p_invert_bit) // R2
    else $error("inversion does not follow code top bit");

  property p_period_wrap;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      running && tick && (phase == phase_last) |=> (phase == '0);
  endproperty
  a_period_wrap: assert property (p_period_wrap) // R3
    else $error("period did not wrap at ratio");

  property p_ratio_mirror;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (code == 4'h0 || code == 4'hf) |-> (phase == '0);
  endproperty
  a_ratio_mirror: assert property (p_ratio_mirror) // R4
    else $error("ratio one code counted phase");

  property p_saturate;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (opt == CLAMP_NONE) && (i_duty_control_level == 8'hff) |-> duty_target == DUTY_FULL;
  endproperty
  a_saturate: assert property (p_saturate) // R8
    else $error("duty not saturated at top");

  property p_both_clamp;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      period_end && (opt == CLAMP_BOTH)
      |=> (duty_lat >= DUTY_CL_LO) && (duty_lat <= DUTY_CL_HI);
  endproperty
  a_both_clamp: assert property (p_both_clamp) // R10
    else $error("two-sided clamp violated");

  property p_one_side;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      period_end && (opt == CLAMP_MIN_ONLY) |=> duty_lat >= DUTY_CL_LO;
  endproperty
  a_one_side: assert property (p_one_side) // R11
    else $error("low clamp violated");

  property p_max_side;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      period_end && (opt == CLAMP_MAX_ONLY) |=> duty_lat <= DUTY_CL_HI;
  endproperty
  a_max_side: assert property (p_max_side) // R11
    else $error("high clamp violated");

  property p_zero_duty;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      running && (duty_lat == '0) |=> o_pwm == $past(code[3]);
  endproperty
  a_zero_duty: assert property (p_zero_duty) // R9
    else $error("zero duty output not steady");

  property p_idle_low;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      !running |=> !o_pwm;
  endproperty
  a_idle_low: assert property (p_idle_low) // R13
    else $error("output active before code settled");

  c_start:    cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) $rose(o_running));
  c_code_chg: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
                o_running && $changed(o_active_code));
  c_inv_tog:  cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
                o_output_invert && $rose(o_pwm));
  c_full:     cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
                running && duty_lat == DUTY_FULL);

endmodule
`default_nettype wire

//--- tb/pwm_load_meter.sv
// output load model: counts clocks the pin spends high while enabled
`timescale 1ns/1ns
`default_nettype none
module pwm_load_meter (
  // clock
  input  wire logic        i_ref_clk,
  // observed pin and gate
  input  wire logic        i_pwm,
  input  wire logic        i_en,
  // result
  output logic [15:0]      o_high_cnt
);
  // ==========================================================
  // high-time counter
  // gate low clears, so each window starts from zero
  always_ff @(posedge i_ref_clk) begin
    if (!i_en) begin
      o_high_cnt <= 16'h0000;
    end else if (i_pwm === 1'b1) begin
      o_high_cnt <= o_high_cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

//--- tb/coded_divider_pwm_oscillator_test.sv
// testbench for the coded divider pwm oscillator
`timescale 1ns/1ns
`default_nettype none
module coded_divider_pwm_oscillator_test;
  import pwm_pkg::*;
  // ==========================================================
  // signals
  logic               clk;
  logic               rst_n;
  logic               pwm;
  logic               inv;
  logic               running;
  logic               en;
  logic [CODE_W-1:0]  code;
  logic [CODE_W-1:0]  act;
  logic [1:0]         opt;
  logic [LEVEL_W-1:0] lvl;
  logic [15:0]        high_cnt;
  int                 n_fail;
  int                 num_checks;
  int                 n_bad;

  coded_divider_pwm_oscillator dut (
    .i_ref_clk            (clk),
    .i_rst_n              (rst_n),
    .i_divider_code       (code),
    .i_clamp_option       (opt),
    .i_duty_control_level (lvl),
    .o_pwm                (pwm),
    .o_output_invert      (inv),
    .o_active_code        (act),
    .o_running            (running)
  );

  pwm_load_meter load (
    .i_ref_clk  (clk),
    .i_pwm      (pwm),
    .i_en       (en),
    .o_high_cnt (high_cnt)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: seen %0d expected %0d", $time, what, seen, exp);
    end
  endtask

  // expected clocks high in one output period, from the duty law and clamps
  function automatic int exp_high(logic [3:0] c, logic [1:0] o, int l);
    int d;
    int k;
    int n;
    int t;
    d = 5 * l - 128;  // level over 0.8 of 256, minus an eighth, in 1/1024 steps
    if (d < 0) d = 0;
    if (d > 1024) d = 1024;
    if ((o == CLAMP_BOTH || o == CLAMP_MIN_ONLY) && d < int'(DUTY_CL_LO)) d = int'(DUTY_CL_LO);
    if ((o == CLAMP_BOTH || o == CLAMP_MAX_ONLY) && d > int'(DUTY_CL_HI)) d = int'(DUTY_CL_HI);
    k = c[3] ? 7 - int'(c[2:0]) : int'(c[2:0]);
    n = 1 << (2 * k);
    t = (d * n + 1023) / 1024 * MASTER_CYCLES;
    return c[3] ? n * MASTER_CYCLES - t : t;
  endfunction

  // settle one period, then measure exactly one period of the pin
  task automatic run(input logic [1:0] o, input logic [7:0] l, input string name);
    int k;
    int p;
    k = code[3] ? 7 - int'(code[2:0]) : int'(code[2:0]);
    p = (1 << (2 * k)) * MASTER_CYCLES;
    @(posedge clk);
    opt <= o;
    lvl <= l;
    repeat (p + 200) @(posedge clk);
    en <= 1'b0;
    @(posedge clk);
    en <= 1'b1;
    repeat (p) @(posedge clk);
    en <= 1'b0;
    #1;
    check(high_cnt, 16'(exp_high(code, o, int'(l))), name);
    $display("test %s done", name);
  endtask

  task automatic new_code(input logic [3:0] c);
    int i;
    @(posedge clk);
    code <= c;
    for (i = 0; i < 10000 && act !== c; i++) begin
      @(posedge clk);
      #1;
    end
    repeat (100) @(posedge clk);
    #1;
    check(16'(act), 16'(c), "active code");
    check(16'(running), 16'h0001, "running");
    check(16'(inv), 16'(c[3]), "invert bit");
    $display("test code %0d done", c);
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog: the sequence needs about 85k clocks
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done;
  end

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    code = 4'h2;
    opt = 2'h0;
    lvl = 8'h66;
    en = 1'b0;
    n_fail = 0;
    num_checks = 0;
    n_bad = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check(16'(pwm), 16'h0000, "pwm in reset");
    check(16'(running), 16'h0000, "running in reset");
    new_code(4'h2);
    run(CLAMP_NONE, 8'h66, "linear duty");
    run(CLAMP_NONE, 8'hff, "top saturates");
    run(CLAMP_MAX_ONLY, 8'h00, "max only bottom");
    run(CLAMP_MIN_ONLY, 8'h00, "min only bottom");
    // a code held for only five ticks must never be taken
    // watched on every clock, so a brief wrong load cannot hide
    @(posedge clk);
    code <= 4'h7;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      if (i == 499) begin
        code <= 4'h2;
      end
      #1;
      if (act !== 4'h2) begin
        n_bad++;
      end
    end
    check(16'(n_bad), 16'h0000, "short code ignored");
    $display("test short code done");
    new_code(4'h3);
    run(CLAMP_BOTH, 8'hff, "both top");
    run(CLAMP_BOTH, 8'h00, "both bottom");
    new_code(4'hc);
    run(CLAMP_MIN_ONLY, 8'h00, "inverted min only bottom");
    run(CLAMP_MIN_ONLY, 8'hff, "inverted min only top");
    new_code(4'hf);
    run(CLAMP_NONE, 8'h00, "ratio one inverted bottom");
    test_done;
  end
endmodule
`default_nettype wire
